/* File: shared/sbmo_defines.svh */
`ifndef SBMO_DEFINES_SVH
`define SBMO_DEFINES_SVH
`define SBMO_MT_UNCACHED 3'h0
`define SBMO_MT_UNCACHED_COMBINING 3'h1
`define SBMO_MT_WRITE_THROUGH 3'h4
`define SBMO_MT_WRITE_PROTECTED 3'h5
`define SBMO_MT_WRITE_BACK 3'h6
`define SBMO_MT_DEFAULT 3'h0
`define SBMO_LINE_OFS_W 5
`define SBMO_RNG_ENTRIES 4
`define SBMO_RNG_IDX_W 2
`endif

/* File: shared/sbmo_pkg.sv */
package sbmo_pkg;
  typedef enum logic [2:0] {
    SBMO_TYPE_UNCACHED = 3'h0,
    SBMO_TYPE_UNCACHED_COMBINING = 3'h1,
    SBMO_TYPE_WRITE_THROUGH = 3'h4,
    SBMO_TYPE_WRITE_PROTECTED = 3'h5,
    SBMO_TYPE_WRITE_BACK = 3'h6
  } sbmo_mtype_type;
  typedef enum logic [4:0] {
    SBMO_ST_IDLE = 5'h01,
    SBMO_ST_STORE = 5'h02,
    SBMO_ST_LOAD = 5'h04,
    SBMO_ST_IO = 5'h08,
    SBMO_ST_LOCK = 5'h10
  } sbmo_state_type;
endpackage : sbmo_pkg

/* File: hdl/sbmo_unit.sv */
`timescale 1ns/10ps
`include "sbmo_defines.svh"

module sbmo_unit import sbmo_pkg::*; #(
  parameter int AW = 32,
  parameter int DW = 32
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic st_valid,
  output logic st_ready,
  input wire logic [AW-1:0] st_addr,
  input wire logic [DW-1:0] st_data,
  input wire logic st_is_io,
  input wire logic ld_valid,
  output logic ld_ready,
  input wire logic [AW-1:0] ld_addr,
  input wire logic ld_split,
  input wire logic lock_valid,
  output logic lock_ready,
  input wire logic [AW-1:0] lock_addr,
  input wire logic lock_split,
  input wire logic serialize_req,
  output logic serialize_done,
  input wire logic intr_ack,
  input wire logic mreg_wr,
  input wire logic [`SBMO_RNG_IDX_W-1:0] mreg_idx,
  input wire logic [AW-1:0] mreg_base,
  input wire logic [AW-1:0] mreg_mask,
  input wire logic [2:0] mreg_type,
  output logic [2:0] ld_mtype,
  output logic ld_cacheable,
  output logic ld_line_fill,
  output logic bus_req,
  output logic bus_wr,
  output logic bus_io,
  output logic [AW-1:0] bus_addr,
  output logic [DW-1:0] bus_data,
  output logic bus_lock,
  input wire logic bus_done,
  input wire logic hold_req_pin,
  output logic hold_ack,
  output logic cache_lock_upd
);
  // range table, written only by the model register write path
  logic [AW-1:0] rng_base_q [`SBMO_RNG_ENTRIES];
  logic [AW-1:0] rng_mask_q [`SBMO_RNG_ENTRIES];
  logic [2:0] rng_type_q [`SBMO_RNG_ENTRIES];
  logic [`SBMO_RNG_ENTRIES-1:0] rng_en_q;
  logic [AW-1:0] buf_addr_q [2];
  logic [DW-1:0] buf_data_q [2];
  logic [1:0] cnt_q;
  logic rd_q;
  logic wr_q;
  sbmo_state_type state_q;
  logic hold_s1_q;
  logic hold_s2_q;
  logic half_q;
  logic split_q;
  logic [AW-1:0] op_addr_q;

  // memory type lookup, first matching entry wins
  function automatic logic [2:0] mtype_of(input logic [AW-1:0] a);
    logic [2:0] t;
    t = `SBMO_MT_DEFAULT;
    for (int i = `SBMO_RNG_ENTRIES - 1; i >= 0; i--) begin
      if (rng_en_q[i] && ((a & rng_mask_q[i]) == (rng_base_q[i] & rng_mask_q[i]))) begin
        t = rng_type_q[i];
      end
    end
    return t;
  endfunction : mtype_of

  // cacheable types fill the line on reads
  function automatic logic cacheable(input logic [2:0] t);
    return (t == `SBMO_MT_WRITE_THROUGH) || (t == `SBMO_MT_WRITE_PROTECTED) ||
      (t == `SBMO_MT_WRITE_BACK);
  endfunction : cacheable

  // range table writes
  always_ff @(posedge mclk) begin
    if (srst) begin
      rng_en_q <= '0;
      for (int i = 0; i < `SBMO_RNG_ENTRIES; i++) begin
        rng_base_q[i] <= '0;
        rng_mask_q[i] <= '0;
        rng_type_q[i] <= `SBMO_MT_DEFAULT;
      end
    end else if (ce && mreg_wr) begin
      rng_en_q[mreg_idx] <= 1'b1;
      rng_base_q[mreg_idx] <= mreg_base;
      rng_mask_q[mreg_idx] <= mreg_mask;
      rng_type_q[mreg_idx] <= mreg_type;
    end
  end

  // hold request synchroniser
  always_ff @(posedge mclk) begin
    if (srst) begin
      hold_s1_q <= 1'b0;
      hold_s2_q <= 1'b0;
    end else if (ce) begin
      hold_s1_q <= hold_req_pin;
      hold_s2_q <= hold_s1_q;
    end
  end

  logic buf_full;
  logic buf_empty;
  logic push;
  logic pop;
  logic grant_hold;
  assign buf_full = (cnt_q == 2'd2);
  assign buf_empty = (cnt_q == 2'd0);
  // hold is granted when idle with no bus lock, including between halves and after reset release
  assign grant_hold = hold_s2_q && (state_q == SBMO_ST_IDLE) && !bus_lock;
  assign push = ce && st_valid && st_ready && !st_is_io;
  assign pop = ce && (state_q == SBMO_ST_STORE) && bus_done && half_q;

  // two-entry store buffer
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q <= 2'd0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      buf_addr_q[0] <= '0;
      buf_addr_q[1] <= '0;
      buf_data_q[0] <= '0;
      buf_data_q[1] <= '0;
    end else if (ce) begin
      if (push) begin
        buf_addr_q[wr_q] <= st_addr;
        buf_data_q[wr_q] <= st_data;
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // store ready, stalled while full or whenever st_is_io is presented
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ready <= 1'b0;
    end else if (ce) begin
      st_ready <= !((cnt_q + {1'b0, push} - {1'b0, pop}) == 2'd2) && !st_is_io;
    end
  end

  // bus sequencer
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= SBMO_ST_IDLE;
      bus_req <= 1'b0;
      bus_wr <= 1'b0;
      bus_io <= 1'b0;
      bus_addr <= '0;
      bus_data <= '0;
      bus_lock <= 1'b0;
      hold_ack <= 1'b0;
      ld_ready <= 1'b0;
      lock_ready <= 1'b0;
      serialize_done <= 1'b0;
      cache_lock_upd <= 1'b0;
      ld_mtype <= `SBMO_MT_DEFAULT;
      ld_cacheable <= 1'b0;
      ld_line_fill <= 1'b0;
      half_q <= 1'b0;
      split_q <= 1'b0;
      op_addr_q <= '0;
    end else if (ce) begin
      ld_ready <= 1'b0;
      lock_ready <= 1'b0;
      serialize_done <= 1'b0;
      cache_lock_upd <= 1'b0;
      hold_ack <= grant_hold;
      case (state_q)
        SBMO_ST_IDLE: begin
          if (grant_hold || hold_ack) begin
            // bus given away, nothing issued
          end else if (ld_valid && !ld_ready) begin
            // a load answered in this cycle is not taken twice
            state_q <= SBMO_ST_LOAD;
            bus_req <= 1'b1;
            bus_wr <= 1'b0;
            bus_io <= 1'b0;
            bus_addr <= split_q ? op_addr_q : ld_addr;
            op_addr_q <= split_q ? op_addr_q : ld_addr;
            half_q <= !ld_split || split_q;
            ld_mtype <= mtype_of(ld_addr);
            ld_cacheable <= cacheable(mtype_of(ld_addr));
            ld_line_fill <= cacheable(mtype_of(ld_addr));
          end else if (!buf_empty) begin
            state_q <= SBMO_ST_STORE;
            bus_req <= 1'b1;
            bus_wr <= 1'b1;
            bus_io <= 1'b0;
            bus_addr <= buf_addr_q[rd_q];
            bus_data <= buf_data_q[rd_q];
            half_q <= 1'b1;
          end else if (st_valid && st_is_io) begin
            state_q <= SBMO_ST_IO;
            bus_req <= 1'b1;
            bus_wr <= 1'b1;
            bus_io <= 1'b1;
            bus_addr <= st_addr;
            bus_data <= st_data;
          end else if (lock_valid && !lock_ready && !intr_ack) begin
            if (lock_split) begin
              state_q <= SBMO_ST_LOCK;
              bus_lock <= 1'b1;
              bus_req <= 1'b1;
              bus_wr <= 1'b0;
              bus_io <= 1'b0;
              bus_addr <= lock_addr;
            end else begin
              cache_lock_upd <= 1'b1;
              lock_ready <= 1'b1;
            end
          end else if (serialize_req && !serialize_done) begin
            serialize_done <= 1'b1;
          end
        end
        SBMO_ST_LOAD: begin
          if (bus_done) begin
            bus_req <= 1'b0;
            if (half_q) begin
              state_q <= SBMO_ST_IDLE;
              split_q <= 1'b0;
              ld_ready <= 1'b1;
            end else begin
              // second half issued after a hold window in idle
              half_q <= 1'b1;
              split_q <= 1'b1;
              state_q <= SBMO_ST_IDLE;
              ld_ready <= 1'b0;
            end
          end
        end
        SBMO_ST_STORE: begin
          if (bus_done) begin
            bus_req <= 1'b0;
            state_q <= SBMO_ST_IDLE;
          end
        end
        SBMO_ST_IO: begin
          if (bus_done) begin
            bus_req <= 1'b0;
            bus_io <= 1'b0;
            state_q <= SBMO_ST_IDLE;
          end
        end
        SBMO_ST_LOCK: begin
          if (bus_done) begin
            if (!bus_wr) begin
              bus_wr <= 1'b1;
            end else begin
              bus_req <= 1'b0;
              bus_wr <= 1'b0;
              bus_lock <= 1'b0;
              lock_ready <= 1'b1;
              state_q <= SBMO_ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= SBMO_ST_IDLE;
        end
      endcase
    end
  end

  // lock never raised from idle during interrupt acknowledge
  a_lock_no_intack: assert property (@(posedge mclk) disable iff (srst)
    (state_q == SBMO_ST_IDLE && intr_ack && ce) |=> !$rose(bus_lock))
    else $error("bus lock raised during interrupt acknowledge");

  // io store only leaves an empty buffer
  a_io_after_drain: assert property (@(posedge mclk) disable iff (srst)
    $rose(bus_io) |-> $past(buf_empty))
    else $error("io store issued while stores buffered");

  // buffer never over two entries
  a_buf_bound: assert property (@(posedge mclk) disable iff (srst)
    cnt_q <= 2'd2)
    else $error("store buffer overflow");

  // io stores never enter the buffer
  a_io_not_buffered: assert property (@(posedge mclk) disable iff (srst)
    (ce && st_valid && st_is_io) |=> cnt_q <= $past(cnt_q))
    else $error("io store entered buffer");

  // unsplit locked op ends in cache without bus
  a_lock_in_cache: assert property (@(posedge mclk) disable iff (srst)
    cache_lock_upd |-> (lock_ready && !bus_lock))
    else $error("in-line lock used the bus");

  // split lock holds bus lock on entry
  a_split_lock: assert property (@(posedge mclk) disable iff (srst)
    (state_q == SBMO_ST_LOCK) |-> bus_lock)
    else $error("split lock without bus lock");

  // no hold granted while locked
  a_hold_not_locked: assert property (@(posedge mclk) disable iff (srst)
    hold_ack |-> !$past(bus_lock))
    else $error("hold granted under bus lock");

  // write-through load fills the line
  a_through_fill: assert property (@(posedge mclk) disable iff (srst)
    (state_q == SBMO_ST_LOAD && ld_mtype == `SBMO_MT_WRITE_THROUGH) |-> ld_line_fill)
    else $error("write-through load without line fill");

  // first half of a split load finishing on the bus
  sequence s_first_half_done;
    ce && (state_q == SBMO_ST_LOAD) && bus_done && !half_q;
  endsequence

  // bus released and idle between the halves
  a_split_gap: assert property (@(posedge mclk) disable iff (srst)
    s_first_half_done |=> (state_q == SBMO_ST_IDLE) && !bus_req)
    else $error("no idle gap between split halves");

  // an answered load is not issued again
  a_load_once: assert property (@(posedge mclk) disable iff (srst)
    (ce && ld_ready) |=> (state_q != SBMO_ST_LOAD))
    else $error("answered load issued again");

  // full buffer refuses further stores
  a_full_stall: assert property (@(posedge mclk) disable iff (srst)
    buf_full |-> !st_ready)
    else $error("store accepted while buffer full");
endmodule : sbmo_unit

/* File: dv/sbmo_bus_mem.sv */
`timescale 1ns/10ps
// memory side of the bus: answers each request lat+1 cycles after taking it
module sbmo_bus_mem #(
  parameter int AW = 32
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [3:0] lat,
  input wire logic bus_req,
  input wire logic bus_wr,
  input wire logic bus_io,
  input wire logic bus_lock,
  input wire logic [AW-1:0] bus_addr,
  output logic bus_done
);
  logic busy_q;
  logic [3:0] cnt_q;
  logic [AW+2:0] log_q[$];
  // count down, pulse done once and log the finished transfer
  always_ff @(posedge mclk) begin
    bus_done <= 1'b0;
    if (srst) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        bus_done <= 1'b1;
        log_q.push_back({bus_lock, bus_io, bus_wr, bus_addr});
      end
    end else if (bus_req && !bus_done) begin
      busy_q <= 1'b1;
      cnt_q <= lat;
    end
  end
endmodule : sbmo_bus_mem

/* File: dv/testbench.sv */
`timescale 1ns/10ps
`include "sbmo_defines.svh"
// directed checks of ordering, bypass, locks, hold and memory typing
module testbench;
  import sbmo_pkg::*;
  logic mclk, srst, ce, st_valid, st_ready, st_is_io, ld_valid, ld_ready, ld_split;
  logic lock_valid, lock_ready, lock_split, serialize_req, serialize_done, intr_ack;
  logic mreg_wr, ld_cacheable, ld_line_fill, bus_req, bus_wr, bus_io, bus_lock;
  logic bus_done, hold_req_pin, hold_ack, cache_lock_upd;
  logic [31:0] st_addr, st_data, ld_addr, lock_addr, mreg_base, mreg_mask, bus_addr, bus_data;
  logic [`SBMO_RNG_IDX_W-1:0] mreg_idx;
  logic [2:0] mreg_type, ld_mtype;
  logic [3:0] lat;
  int mismatches = 0;
  int samples_checked = 0;
  sbmo_unit sbmo_unit_i (.mclk, .srst, .ce, .st_valid, .st_ready, .st_addr, .st_data,
    .st_is_io, .ld_valid, .ld_ready, .ld_addr, .ld_split, .lock_valid, .lock_ready,
    .lock_addr, .lock_split, .serialize_req, .serialize_done, .intr_ack, .mreg_wr,
    .mreg_idx, .mreg_base, .mreg_mask, .mreg_type, .ld_mtype, .ld_cacheable,
    .ld_line_fill, .bus_req, .bus_wr, .bus_io, .bus_addr, .bus_data, .bus_lock,
    .bus_done, .hold_req_pin, .hold_ack, .cache_lock_upd);
  sbmo_bus_mem sbmo_bus_mem_i (.mclk, .srst, .lat, .bus_req, .bus_wr, .bus_io,
    .bus_lock, .bus_addr, .bus_done);
  // clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic end_sim;
    $display("compared %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [34:0] exp, input logic [34:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [34:0] ent(input int k);
    return sbmo_bus_mem_i.log_q[k];
  endfunction : ent
  function automatic int cnt();
    return sbmo_bus_mem_i.log_q.size();
  endfunction : cnt
  task automatic wt(ref logic s, input int n);
    repeat (n) begin
      @(negedge mclk);
      if (s === 1'b1) break;
    end
  endtask : wt
  task automatic do_store(input logic [31:0] a);
    @(posedge mclk);
    st_valid <= 1'b1;
    st_addr <= a;
    st_data <= ~a;
    wt(st_ready, 60);
    @(posedge mclk);
    st_valid <= 1'b0;
  endtask : do_store
  task automatic do_load(input logic [31:0] a);
    @(posedge mclk);
    ld_valid <= 1'b1;
    ld_addr <= a;
    wt(ld_ready, 80);
    chk("ld_ready", 1, ld_ready);
    @(posedge mclk);
    ld_valid <= 1'b0;
  endtask : do_load
  task automatic do_ser;
    @(posedge mclk) serialize_req <= 1'b1;
    wt(serialize_done, 200);
    chk("serialize_done", 1, serialize_done);
    @(posedge mclk) serialize_req <= 1'b0;
  endtask : do_ser
  task automatic mreg_set(input logic [1:0] i, input logic [31:0] b, input logic [2:0] t);
    @(posedge mclk);
    mreg_wr <= 1'b1;
    mreg_idx <= i;
    mreg_base <= b;
    mreg_mask <= 32'hffff_f000;
    mreg_type <= t;
    @(posedge mclk) mreg_wr <= 1'b0;
  endtask : mreg_set
  // hold raised at reset release is granted
  task automatic t_hold_reset;
    @(posedge mclk);
    hold_req_pin <= 1'b1;
    srst <= 1'b0;
    wt(hold_ack, 8);
    chk("hold_ack reset", 1, hold_ack);
    chk("bus_req in hold", 0, bus_req);
    @(posedge mclk) hold_req_pin <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask : t_hold_reset
  // stores fill the buffer, a load passes the one still buffered, serialize drains
  task automatic t_order;
    int n0;
    n0 = cnt();
    lat <= 4'h8;
    for (int i = 0; i < 3; i++) do_store(32'h100 + 32'(i * 4));
    @(negedge mclk);
    @(negedge mclk);
    chk("st_ready full", 0, st_ready);
    do_load(32'h200);
    do_ser;
    chk("drained", n0 + 4, cnt());
    chk("wr 0", {3'b001, 32'h100}, ent(n0));
    chk("wr 1", {3'b001, 32'h104}, ent(n0 + 1));
    chk("ld pass", {3'b000, 32'h200}, ent(n0 + 2));
    chk("wr 2", {3'b001, 32'h108}, ent(n0 + 3));
  endtask : t_order
  // io store waits for the buffer, then goes out unbuffered
  task automatic t_io;
    int n0;
    n0 = cnt();
    do_store(32'h300);
    @(posedge mclk);
    st_valid <= 1'b1;
    st_is_io <= 1'b1;
    st_addr <= 32'h3f8;
    st_data <= 32'h0000_00a5;
    wt(bus_io, 60);
    chk("io after drain", n0 + 1, cnt());
    chk("io bus", {3'b011, 32'h3f8}, {bus_lock, bus_io, bus_wr, bus_addr});
    chk("io data", 32'h0000_00a5, bus_data);
    chk("io not taken", 0, st_ready);
    @(posedge mclk);
    st_valid <= 1'b0;
    st_is_io <= 1'b0;
    do_ser;
  endtask : t_io
  // locks: blocked by interrupt ack, in cache, then split on the bus
  task automatic t_lock;
    int n0;
    logic seen;
    n0 = cnt();
    seen = 1'b0;
    lat <= 4'h2;
    @(posedge mclk);
    intr_ack <= 1'b1;
    lock_valid <= 1'b1;
    lock_split <= 1'b0;
    lock_addr <= 32'h400;
    repeat (10) begin
      @(negedge mclk);
      seen |= bus_lock | lock_ready | cache_lock_upd;
    end
    chk("lock in intr ack", 0, seen);
    @(posedge mclk) intr_ack <= 1'b0;
    repeat (40) begin
      @(negedge mclk);
      seen |= cache_lock_upd;
      if (lock_ready === 1'b1) break;
    end
    chk("cache update", 1, seen);
    chk("no write back", n0, cnt());
    @(posedge mclk) lock_valid <= 1'b0;
    @(posedge mclk);
    lock_valid <= 1'b1;
    lock_split <= 1'b1;
    lock_addr <= 32'h41e;
    wt(lock_ready, 60);
    chk("lock rd", {3'b100, 32'h41e}, ent(n0));
    chk("lock wr", {3'b101, 32'h41e}, ent(n0 + 1));
    @(posedge mclk) lock_valid <= 1'b0;
  endtask : t_lock
  // hold granted between the two halves of a split load
  task automatic t_split;
    int n0;
    n0 = cnt();
    lat <= 4'h6;
    @(posedge mclk);
    ld_valid <= 1'b1;
    ld_split <= 1'b1;
    ld_addr <= 32'h5fe;
    wt(bus_req, 20);
    @(posedge mclk) hold_req_pin <= 1'b1;
    wt(hold_ack, 40);
    chk("hold between", n0 + 1, cnt());
    chk("bus idle", 0, bus_req);
    @(posedge mclk) hold_req_pin <= 1'b0;
    wt(ld_ready, 60);
    chk("split halves", n0 + 2, cnt());
    @(posedge mclk);
    ld_valid <= 1'b0;
    ld_split <= 1'b0;
  endtask : t_split
  // every memory type through the range table, then the default
  task automatic t_types;
    sbmo_mtype_type tt[5];
    logic [4:0] cac;
    tt = '{SBMO_TYPE_UNCACHED, SBMO_TYPE_UNCACHED_COMBINING, SBMO_TYPE_WRITE_THROUGH,
      SBMO_TYPE_WRITE_PROTECTED, SBMO_TYPE_WRITE_BACK};
    cac = 5'h1c;
    for (int i = 1; i < 4; i++) mreg_set(2'(i), 32'h1000_0000, SBMO_TYPE_WRITE_BACK);
    for (int i = 0; i < 5; i++) begin
      mreg_set(2'h0, 32'h0002_0000, tt[i]);
      do_load(32'h0002_0040);
      chk("mtype", tt[i], ld_mtype);
      chk("cacheable", cac[i], ld_cacheable);
      chk("line fill", cac[i], ld_line_fill);
    end
    do_load(32'h0900_0000);
    chk("default type", SBMO_TYPE_UNCACHED, ld_mtype);
  endtask : t_types
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    end_sim;
  end
  // main sequence
  initial begin
    {srst, ce} = 2'b11;
    {st_valid, st_is_io, ld_valid, ld_split, lock_valid, lock_split} = '0;
    {serialize_req, intr_ack, mreg_wr, hold_req_pin} = '0;
    {st_addr, st_data, ld_addr, lock_addr, mreg_base, mreg_mask} = '0;
    {mreg_idx, mreg_type, lat} = '0;
    repeat (20) @(posedge mclk);
    t_hold_reset;
    t_order;
    t_io;
    t_lock;
    t_split;
    t_types;
    end_sim;
  end
endmodule : testbench
